/* pwm_pkg.sv */
// Constants, types and register map of the word move, convert and add/subtract unit
// ============================================================================
// Behaviour
// RULE1: Fill-move writes one source value into n consecutive destinations, n at most 512.
// RULE2: Fill locations past the end of the word area are silently dropped.
// RULE3: Issuer keeps fill destinations off the index registers; 32-bit uses the pair.
// RULE4: Exchange swaps both operands, and repeats on every scan in continuous form.
// RULE5: Byte-swap mode with equal operands swaps low and high bytes, also in 32-bit.
// RULE6: Byte-swap mode with different operands raises error, stores code, changes nothing.
// RULE7: Binary-to-BCD writes BCD form; 16-bit values outside 0 to 9999 are errors.
// RULE8: 32-bit binary-to-BCD values outside 0 to 99999999 are errors.
// RULE9: On a binary-to-BCD range error set error flag, store code, keep destination.
// RULE10: BCD-to-binary decodes four or eight digits and writes word or word pair.
// RULE11: An invalid BCD nibble raises error flag, stores code and skips the conversion.
// RULE12: Issuer never gives an immediate constant as BCD-to-binary source.
// RULE13: Top bit of every arithmetic operand and result is a two's-complement sign.
// RULE14: Addition stores the signed sum of both sources at 16 or 32 bits.
// RULE15: Zero flag is set when an addition or subtraction result is zero.
// RULE16: Borrow flag is set when the true result is below the width minimum.
// RULE17: Carry flag is set when the true result is above the width maximum.
// RULE18: 32-bit operands are the named word plus the next word as upper half.
// RULE19: Continuous arithmetic executes on every enabled scan.
// RULE20: Pulsed arithmetic executes once, on the scan where the enable rises.
// RULE21: Subtraction stores first source minus second, signed.
// RULE22: Subtraction handles flags, pairing and execution form exactly as addition.
// RULE23: Flags and destinations change only on scans where the instruction executes.
package pwm_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_SRC1 = 12'h004;
  localparam logic [11:0] REG_SRC2 = 12'h008;
  localparam logic [11:0] REG_DST = 12'h00c;
  localparam logic [11:0] REG_COUNT = 12'h010;
  localparam logic [11:0] REG_SCAN = 12'h014;
  localparam logic [11:0] REG_STATUS = 12'h018;
  localparam logic [11:0] REG_ERR = 12'h01c;
  localparam logic [11:0] REG_MADDR = 12'h020;
  localparam logic [11:0] REG_MDATA = 12'h024;

  // Status bit positions; writing one to the error bit clears it
  localparam int STS_BUSY = 0;
  localparam int STS_ZERO = 1;
  localparam int STS_BORROW = 2;
  localparam int STS_CARRY = 3;
  localparam int STS_ERR = 4;

  // Opcodes held in the control register
  localparam logic [2:0] OP_FILL = 3'h0;
  localparam logic [2:0] OP_SWAP = 3'h1;
  localparam logic [2:0] OP_BIN2BCD = 3'h2;
  localparam logic [2:0] OP_BCD2BIN = 3'h3;
  localparam logic [2:0] OP_ADD = 3'h4;
  localparam logic [2:0] OP_SUB = 3'h5;

  // Error codes, values arbitrary
  localparam logic [15:0] ERR_SWAP_MODE = 16'h0001;
  localparam logic [15:0] ERR_BCD_RANGE = 16'h0002;
  localparam logic [15:0] ERR_BCD_DIGIT = 16'h0003;
  localparam logic [15:0] ERR_BAD_OP = 16'h0004;

  // Limits and reset values
  localparam int MEM_WORDS_DEF = 1024;
  localparam logic [9:0] FILL_MAX = 10'd512;
  localparam logic signed [33:0] BCD16_MAX = 34'sd9999;
  localparam logic signed [33:0] BCD32_MAX = 34'sd99999999;
  localparam logic signed [33:0] S16_MAX = 34'sd32767;
  localparam logic signed [33:0] S16_MIN = -34'sd32768;
  localparam logic signed [33:0] S32_MAX = 34'sd2147483647;
  localparam logic signed [33:0] S32_MIN = -34'sd2147483648;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // Control register layout, bit 0 upward: enable, pulsed, wide, byte swap, opcode
  typedef struct packed {
    logic [2:0] opcode;
    logic byte_swap_mode_flag;
    logic wide;
    logic pulsed;
    logic enable;
  } pwm_ctrl_s;

  // One word write into the device area
  typedef struct packed {
    logic en;
    logic [17:0] addr;
    logic [15:0] data;
  } pwm_wr_s;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FILL} pwm_state_e;

endpackage : pwm_pkg

/* pwm_seq_model.sv */
// Scan sequencer model: issues instructions and operands over APB
`timescale 1ns/1ps
`default_nettype none
module pwm_seq_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; operands are always word addresses, never constants or index
  // registers, and wide operands name the lower, even word
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    // Released lines show a changed value so stale data cannot pass
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : pwm_seq_model
`default_nettype wire

/* pwm_word_unit.sv */
// Word move, BCD convert and signed add/subtract unit with APB register access
`timescale 1ns/1ps
`default_nettype none
module pwm_word_unit
  import pwm_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter int AW = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy,
  output logic zero_flag,
  output logic borrow_flag,
  output logic carry_flag,
  output logic operation_error_flag
);

  // ==========================================================================
  // State and storage
  logic [15:0] mem [MEM_WORDS];
  pwm_ctrl_s ctrl_reg;
  logic [15:0] src1_reg;
  logic [15:0] src2_reg;
  logic [15:0] dst_reg;
  logic [9:0] count_reg;
  logic [15:0] maddr_reg;
  logic [15:0] error_code_word;
  logic en_prev_reg;
  pwm_state_e state_reg;
  logic [9:0] fill_idx_reg;
  logic [9:0] fill_cnt_reg;
  logic [31:0] fill_src_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic busy_reg;
  logic zero_reg;
  logic borrow_reg;
  logic carry_reg;
  logic op_err_reg;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign busy = busy_reg;
  assign zero_flag = zero_reg;
  assign borrow_flag = borrow_reg;
  assign carry_flag = carry_reg;
  assign operation_error_flag = op_err_reg;

  // ==========================================================================
  // Helpers
  // Out-of-area reads return zero so a short area never yields stale data
  function automatic logic [15:0] rd16(input logic [17:0] a);
    if (a < 18'(MEM_WORDS)) begin
      rd16 = mem[a[AW-1:0]];
    end else begin
      rd16 = 16'h0000;
    end
  endfunction : rd16

  function automatic logic [17:0] inc18(input logic [17:0] a);
    inc18 = a + 18'd1;
  endfunction : inc18

  // Shift-and-add-three over the 27 bits that eight digits can need
  function automatic logic [31:0] to_bcd(input logic [26:0] v);
    logic [58:0] sr;
    sr = {32'h0000_0000, v};
    for (int i = 0; i < 27; i++) begin
      for (int d = 0; d < 8; d++) begin
        if (sr[27+4*d +: 4] >= 4'h5) begin
          sr[27+4*d +: 4] = sr[27+4*d +: 4] + 4'h3;
        end
      end
      sr = {sr[57:0], 1'b0};
    end
    to_bcd = sr[58:27];
  endfunction : to_bcd

  function automatic logic bcd_ok(input logic [31:0] v, input logic wide);
    bcd_ok = 1'b1;
    for (int d = 0; d < 8; d++) begin
      if ((d < 4 || wide) && v[4*d +: 4] > 4'h9) begin
        bcd_ok = 1'b0;
      end
    end
  endfunction : bcd_ok

  function automatic logic [31:0] bcd_val(input logic [31:0] v, input logic wide);
    bcd_val = 32'h0000_0000;
    for (int d = 7; d >= 0; d--) begin
      if (d < 4 || wide) begin
        bcd_val = bcd_val * 32'h0000_000a + {28'h000_0000, v[4*d +: 4]};
      end
    end
  endfunction : bcd_val

  // ==========================================================================
  // APB decode
  logic setup_ph;
  logic apb_wr;
  logic idle;
  logic mapped;
  assign setup_ph = psel & ~penable;
  assign apb_wr = psel & penable & pready_reg & pwrite;
  assign idle = (state_reg == ST_IDLE);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_MDATA);

  // ==========================================================================
  // Operand fetch and arithmetic
  logic [17:0] s1_a;
  logic [17:0] s2_a;
  logic [17:0] d_a;
  logic [31:0] a32;
  logic [31:0] b32;
  logic signed [33:0] a_s;
  logic signed [33:0] b_s;
  logic signed [33:0] sum;
  logic [31:0] bcd_res;
  logic [31:0] bin_res;
  logic bcd_range_err;
  logic digit_ok;

  assign s1_a = {2'b00, src1_reg};
  assign s2_a = {2'b00, src2_reg};
  assign d_a = {2'b00, dst_reg};
  // Fetch in a process so a word-area write also refreshes the operands
  always_comb begin
    a32 = {rd16(inc18(s1_a)), rd16(s1_a)}; // RULE18
    b32 = {rd16(inc18(s2_a)), rd16(s2_a)}; // RULE18
  end

  // Sign-extend both sources to 34 bits so the true result is never cut
  always_comb begin
    if (ctrl_reg.wide) begin
      a_s = {{2{a32[31]}}, a32}; // RULE13
      b_s = {{2{b32[31]}}, b32};
    end else begin
      a_s = {{18{a32[15]}}, a32[15:0]}; // RULE13
      b_s = {{18{b32[15]}}, b32[15:0]};
    end
    if (ctrl_reg.opcode == OP_SUB) begin
      sum = a_s - b_s; // RULE21
    end else begin
      sum = a_s + b_s; // RULE14
    end
  end

  // Binary-to-BCD conversion: negative sources are out of range as well
  assign bcd_range_err = (a_s < 34'sd0) || (a_s > (ctrl_reg.wide ? BCD32_MAX : BCD16_MAX)); // RULE7 RULE8
  assign bcd_res = to_bcd(a_s[26:0]);
  assign digit_ok = bcd_ok(a32, ctrl_reg.wide); // RULE11
  assign bin_res = bcd_val(a32, ctrl_reg.wide); // RULE10

  // ==========================================================================
  // Execution results for one run cycle
  logic [31:0] res;
  logic res_we;
  logic err;
  logic [15:0] err_code;
  logic is_arith;

  always_comb begin
    res = 32'h0000_0000;
    res_we = 1'b0;
    err = 1'b0;
    err_code = 16'h0000;
    is_arith = 1'b0;
    unique case (ctrl_reg.opcode)
      OP_FILL, OP_SWAP: begin
        if (ctrl_reg.opcode == OP_SWAP && ctrl_reg.byte_swap_mode_flag && src1_reg != src2_reg) begin
          err = 1'b1; // RULE6
          err_code = ERR_SWAP_MODE;
        end
      end
      OP_BIN2BCD: begin
        if (bcd_range_err) begin
          err = 1'b1; // RULE9
          err_code = ERR_BCD_RANGE;
        end else begin
          res = bcd_res;
          res_we = 1'b1;
        end
      end
      OP_BCD2BIN: begin
        if (!digit_ok) begin
          err = 1'b1; // RULE11
          err_code = ERR_BCD_DIGIT;
        end else begin
          res = bin_res;
          res_we = 1'b1;
        end
      end
      OP_ADD, OP_SUB: begin
        res = sum[31:0]; // RULE14 RULE21 RULE22
        res_we = 1'b1;
        is_arith = 1'b1;
      end
      default: begin
        err = 1'b1;
        err_code = ERR_BAD_OP;
      end
    endcase
  end

  // ==========================================================================
  // Write ports into the word area; later ports win on equal addresses
  pwm_wr_s wp [5];
  logic [17:0] fill_a;
  assign fill_a = d_a + (ctrl_reg.wide ? {7'h00, fill_idx_reg, 1'b0} : {8'h00, fill_idx_reg});

  always_comb begin
    for (int k = 0; k < 5; k++) begin
      wp[k] = '0;
    end
    if (state_reg == ST_FILL) begin
      wp[0] = '{en: 1'b1, addr: fill_a, data: fill_src_reg[15:0]}; // RULE1
      wp[1] = '{en: ctrl_reg.wide, addr: inc18(fill_a), data: fill_src_reg[31:16]};
    end else if (state_reg == ST_RUN) begin
      if (ctrl_reg.opcode == OP_SWAP && !err) begin
        if (ctrl_reg.byte_swap_mode_flag) begin
          wp[0] = '{en: 1'b1, addr: s1_a, data: {a32[7:0], a32[15:8]}}; // RULE5
          wp[1] = '{en: ctrl_reg.wide, addr: inc18(s1_a), data: {a32[23:16], a32[31:24]}};
        end else begin
          wp[0] = '{en: 1'b1, addr: s1_a, data: b32[15:0]}; // RULE4
          wp[1] = '{en: 1'b1, addr: s2_a, data: a32[15:0]};
          wp[2] = '{en: ctrl_reg.wide, addr: inc18(s1_a), data: b32[31:16]};
          wp[3] = '{en: ctrl_reg.wide, addr: inc18(s2_a), data: a32[31:16]};
        end
      end else if (res_we) begin
        wp[0] = '{en: 1'b1, addr: d_a, data: res[15:0]};
        wp[1] = '{en: ctrl_reg.wide, addr: inc18(d_a), data: res[31:16]}; // RULE18
      end
    end
    wp[4] = '{en: apb_wr && paddr == REG_MDATA && idle, addr: {2'b00, maddr_reg},
              data: pwdata[15:0]};
  end

  // Word area: writes beyond the last word are dropped
  always_ff @(posedge pclk) begin
    for (int k = 0; k < 5; k++) begin
      if (wp[k].en && wp[k].addr < 18'(MEM_WORDS)) begin // RULE2
        mem[wp[k].addr[AW-1:0]] <= wp[k].data;
      end
    end
  end

  // ==========================================================================
  // Scan handling and sequencing
  logic scan_req;
  logic exec;
  logic [9:0] cnt_eff;
  assign scan_req = apb_wr && paddr == REG_SCAN && idle;
  // Continuous form runs on each enabled scan, pulsed only on the rising scan
  assign exec = ctrl_reg.enable && (!ctrl_reg.pulsed || !en_prev_reg); // RULE19 RULE20 RULE4
  assign cnt_eff = (count_reg > FILL_MAX) ? FILL_MAX : count_reg; // RULE1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      fill_idx_reg <= 10'h000;
      fill_cnt_reg <= 10'h000;
      fill_src_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (scan_req) begin
            en_prev_reg <= ctrl_reg.enable;
            if (exec && ctrl_reg.opcode == OP_FILL) begin
              // Source latched once so an overlapping fill cannot feed itself
              fill_src_reg <= a32;
              fill_cnt_reg <= cnt_eff;
              fill_idx_reg <= 10'h000;
              if (cnt_eff != 10'h000) begin
                state_reg <= ST_FILL;
                busy_reg <= 1'b1;
              end
            end else if (exec) begin
              state_reg <= ST_RUN;
              busy_reg <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
        end
        ST_FILL: begin
          fill_idx_reg <= fill_idx_reg + 10'h001;
          // Stop at n or as soon as the current element falls off the area
          if (fill_idx_reg + 10'h001 >= fill_cnt_reg || fill_a >= 18'(MEM_WORDS)) begin // RULE2
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Status flags: arithmetic flags touched only on a run cycle; error set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= 1'b0;
      borrow_reg <= 1'b0;
      carry_reg <= 1'b0;
      op_err_reg <= 1'b0;
      error_code_word <= 16'h0000;
    end else begin
      if (state_reg == ST_RUN && is_arith) begin // RULE23
        zero_reg <= ctrl_reg.wide ? (sum[31:0] == 32'h0) : (sum[15:0] == 16'h0); // RULE15
        borrow_reg <= sum < (ctrl_reg.wide ? S32_MIN : S16_MIN); // RULE16
        carry_reg <= sum > (ctrl_reg.wide ? S32_MAX : S16_MAX); // RULE17
      end
      if (state_reg == ST_RUN && err) begin
        op_err_reg <= 1'b1; // RULE6 RULE9 RULE11
        error_code_word <= err_code;
      end else if (apb_wr && paddr == REG_STATUS && pwdata[STS_ERR]) begin
        op_err_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers; operand setup is frozen while an instruction runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      src1_reg <= 16'h0000;
      src2_reg <= 16'h0000;
      dst_reg <= 16'h0000;
      count_reg <= 10'h000;
      maddr_reg <= 16'h0000;
    end else if (apb_wr && idle) begin
      unique case (paddr)
        REG_CTRL: ctrl_reg <= pwdata[6:0];
        REG_SRC1: src1_reg <= pwdata[15:0];
        REG_SRC2: src2_reg <= pwdata[15:0];
        REG_DST: dst_reg <= pwdata[15:0];
        REG_COUNT: count_reg <= pwdata[9:0];
        REG_MADDR: maddr_reg <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // APB answer: data captured in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_ph;
      if (setup_ph) begin
        pslverr_reg <= !mapped;
        unique case (paddr)
          REG_CTRL: prdata_reg <= {25'h000_0000, ctrl_reg};
          REG_SRC1: prdata_reg <= {16'h0000, src1_reg};
          REG_SRC2: prdata_reg <= {16'h0000, src2_reg};
          REG_DST: prdata_reg <= {16'h0000, dst_reg};
          REG_COUNT: prdata_reg <= {22'h00_0000, count_reg};
          REG_STATUS: prdata_reg <= {27'h000_0000, op_err_reg, carry_reg, borrow_reg,
                                     zero_reg, busy_reg};
          REG_ERR: prdata_reg <= {16'h0000, error_code_word};
          REG_MADDR: prdata_reg <= {16'h0000, maddr_reg};
          REG_MDATA: prdata_reg <= {16'h0000, rd16({2'b00, maddr_reg})};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end else if (!psel) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

endmodule : pwm_word_unit
`default_nettype wire

/* pwm_word_unit_assertions.sv */
// Port-level checker for the word move, convert and add/subtract unit
`timescale 1ns/1ps
`default_nettype none
module pwm_word_unit_assertions
  import pwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy,
  input wire logic zero_flag,
  input wire logic borrow_flag,
  input wire logic carry_flag,
  input wire logic operation_error_flag
);
  logic [9:0] busy_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Helper logic
  // Length of the current busy run; a fill may never outlast its limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 10'h000;
    end else begin
      busy_cnt <= busy ? busy_cnt + 10'h001 : 10'h000;
    end
  end

  // APB phases as seen at the ports
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence

  // ==========================================================================
  // Assertions
  // Flags move only as an execution ends, never between scans
  flags_only_exec_a: assert property ($changed({zero_flag, borrow_flag, carry_flag}) |-> $fell(busy))
    else $error("arith flags changed outside an execution");
  range_excl_a: assert property (!(borrow_flag && carry_flag))
    else $error("borrow and carry set together");
  err_set_exec_a: assert property ($rose(operation_error_flag) |-> $fell(busy))
    else $error("error flag rose outside an execution");
  err_sticky_a: assert property ($fell(operation_error_flag)
      |-> $past(psel && penable && pwrite && paddr == REG_STATUS && pwdata[STS_ERR]))
    else $error("error flag dropped without a clear");
  busy_after_scan_a: assert property ($rose(busy)
      |-> $past(psel && penable && pwrite && paddr == REG_SCAN))
    else $error("execution started without a scan");
  fill_bound_a: assert property (busy_cnt <= 10'd512)
    else $error("busy run longer than the fill limit");
  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("register access not answered in one cycle");
  unmapped_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  scan_seen_c: cover property ($past(psel && penable && pwrite && paddr == REG_SCAN) && busy);
endmodule : pwm_word_unit_assertions

bind pwm_word_unit pwm_word_unit_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy), .zero_flag(zero_flag),
  .borrow_flag(borrow_flag), .carry_flag(carry_flag),
  .operation_error_flag(operation_error_flag));
`default_nettype wire

/* pwm_word_unit_tb.sv */
// Self-checking bench for the word move, convert and add/subtract unit
`timescale 1ns/1ps
`default_nettype none
module pwm_word_unit_tb
  import pwm_pkg::*;
;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [15:0] va;
    logic [15:0] vb;
    logic [3:0] s2;
    logic [3:0] at;
    logic [15:0] ex;
    logic [4:0] st;
    logic [15:0] ec;
  } pwm_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, e;
  logic zero_flag, borrow_flag, carry_flag, operation_error_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  pwm_row_s rows [16];

  pwm_word_unit #(.MEM_WORDS(16), .AW(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy), .zero_flag(zero_flag),
    .borrow_flag(borrow_flag), .carry_flag(carry_flag),
    .operation_error_flag(operation_error_flag));
  pwm_seq_model SEQ (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ==========================================================================
  // Clock, reset and hang guard
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  end
  // Whole run needs about a thousand cycles; far beyond that means a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    SEQ.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    SEQ.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic mw(input logic [3:0] a, input logic [15:0] d);
    wr(REG_MADDR, {28'h0, a});
    wr(REG_MDATA, {16'h0, d});
  endtask : mw
  task automatic mr(input logic [3:0] a);
    wr(REG_MADDR, {28'h0, a});
    rd(REG_MDATA);
  endtask : mr
  task automatic setup(input logic [6:0] c, input logic [3:0] s1, s2, d);
    wr(REG_CTRL, {25'h0, c});
    wr(REG_SRC1, {28'h0, s1});
    wr(REG_SRC2, {28'h0, s2});
    wr(REG_DST, {28'h0, d});
  endtask : setup
  // Poll busy with a bound; a stuck unit then fails its result checks
  task automatic scan();
    int n;
    n = 0;
    wr(REG_SCAN, 32'h1);
    rd(REG_STATUS);
    while (q[STS_BUSY] !== 1'b0 && n < 600) begin
      rd(REG_STATUS);
      n++;
    end
  endtask : scan
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Main sequence
  initial begin
    rows = '{
      '{7'h41, 16'h0005, 16'hfff8, 4'h4, 4'h8, 16'hfffd, 5'h00, 16'h0},
      '{7'h41, 16'h7fff, 16'h0001, 4'h4, 4'h8, 16'h8000, 5'h08, 16'h0},
      '{7'h41, 16'h8000, 16'hffff, 4'h4, 4'h8, 16'h7fff, 5'h04, 16'h0},
      '{7'h41, 16'h0001, 16'hffff, 4'h4, 4'h8, 16'h0000, 5'h02, 16'h0},
      '{7'h51, 16'h0005, 16'h0005, 4'h4, 4'h8, 16'h0000, 5'h02, 16'h0},
      '{7'h51, 16'h8000, 16'h0001, 4'h4, 4'h8, 16'h7fff, 5'h04, 16'h0},
      '{7'h51, 16'h7fff, 16'hffff, 4'h4, 4'h8, 16'h8000, 5'h08, 16'h0},
      '{7'h21, 16'h04d2, 16'h0000, 4'h4, 4'h8, 16'h1234, 5'h08, 16'h0},
      '{7'h31, 16'h9999, 16'h0000, 4'h4, 4'h8, 16'h270f, 5'h08, 16'h0},
      '{7'h11, 16'h1111, 16'h2222, 4'h4, 4'h2, 16'h2222, 5'h08, 16'h0},
      '{7'h19, 16'h1234, 16'h0000, 4'h2, 4'h2, 16'h3412, 5'h08, 16'h0},
      '{7'h21, 16'h2710, 16'h0000, 4'h4, 4'h8, 16'h5a5a, 5'h18, ERR_BCD_RANGE},
      '{7'h21, 16'hffff, 16'h0000, 4'h4, 4'h8, 16'h5a5a, 5'h18, ERR_BCD_RANGE},
      '{7'h31, 16'h12a4, 16'h0000, 4'h4, 4'h8, 16'h5a5a, 5'h18, ERR_BCD_DIGIT},
      '{7'h19, 16'h1234, 16'h2222, 4'h4, 4'h2, 16'h1234, 5'h18, ERR_SWAP_MODE},
      '{7'h61, 16'h0000, 16'h0000, 4'h4, 4'h8, 16'h5a5a, 5'h18, ERR_BAD_OP}};
    @(posedge presetn);
    // Reset values and refused addresses
    rd(REG_STATUS);
    check(q, 32'h0);
    rd(REG_CTRL);
    check(q, {25'h0, CTRL_RESET});
    rd(12'h028);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    rd(12'h002);
    check({31'h0, e}, 32'h1);
    $display("test reset done");
    // Ordinary cases, one row each
    foreach (rows[i]) begin
      mw(4'h2, rows[i].va);
      mw(4'h4, rows[i].vb);
      mw(4'h8, 16'h5a5a);
      setup(rows[i].ctrl, 4'h2, rows[i].s2, 4'h8);
      scan();
      mr(rows[i].at);
      check(q, {16'h0, rows[i].ex});
      rd(REG_STATUS);
      check(q, {27'h0, rows[i].st});
      check({27'h0, operation_error_flag, carry_flag, borrow_flag, zero_flag, busy},
            {27'h0, rows[i].st});
      if (rows[i].st[STS_ERR]) begin
        rd(REG_ERR);
        check(q, {16'h0, rows[i].ec});
        wr(REG_STATUS, 32'h10);
      end
    end
    $display("test rows done");
    // Continuous accumulation, then pulsed runs once per rising enable
    mw(4'h8, 16'h0000);
    mw(4'h4, 16'h0001);
    setup(7'h41, 4'h8, 4'h4, 4'h8);
    scan();
    scan();
    mr(4'h8);
    check(q, 32'h2);
    wr(REG_CTRL, 32'h42);
    scan();
    wr(REG_CTRL, 32'h43);
    scan();
    scan();
    mr(4'h8);
    check(q, 32'h3);
    $display("test scan forms done");
    // Wide add: low-word carry ripples into the paired upper word
    mw(4'h2, 16'hffff);
    mw(4'h3, 16'h7fff);
    mw(4'h4, 16'h0001);
    mw(4'h5, 16'h0000);
    setup(7'h45, 4'h2, 4'h4, 4'h8);
    scan();
    mr(4'h8);
    check(q, 32'h0);
    mr(4'h9);
    check(q, 32'h8000);
    rd(REG_STATUS);
    check(q, 32'h08);
    $display("test wide add done");
    // Continuous swap repeats on each scan
    mw(4'h2, 16'haaaa);
    mw(4'h4, 16'h5555);
    setup(7'h11, 4'h2, 4'h4, 4'h0);
    scan();
    mr(4'h2);
    check(q, 32'h5555);
    scan();
    mr(4'h2);
    check(q, 32'haaaa);
    $display("test swap repeat done");
    // Fill running off the end of the area; neighbours untouched
    mw(4'h0, 16'h0bad);
    mw(4'hc, 16'h0bad);
    mw(4'h2, 16'h7777);
    setup(7'h01, 4'h2, 4'h0, 4'hd);
    wr(REG_COUNT, 32'h5);
    scan();
    for (int i = 13; i < 16; i++) begin
      mr(4'(i));
      check(q, 32'h7777);
    end
    mr(4'hc);
    check(q, 32'h0bad);
    mr(4'h0);
    check(q, 32'h0bad);
    $display("test fill done");
    print_verdict();
  end
endmodule : pwm_word_unit_tb
`default_nettype wire
